// ### logic/fpm_top.v
// Fixed-point multiply block with optional stage registers and status port
`timescale 1ns/10ps
`default_nettype none
`include "fpm_map.vh"

// Notes on behaviour
// RULE1 - Six modes by parameter; default dual independent
// RULE2 - Each operand signedness parameter, default unsigned
// RULE3 - First x operand width zero to 27
// RULE4 - First y or cascade width 1-27, default 18
// RULE5 - Second x operand width 0-36, default 18
// RULE6 - Second y operand width 0-19, default 18
// RULE7 - Operand stages bypass or enable; default enable zero for first and second, bypassed for third and fourth
// RULE8 - Third, fourth operands only in quad mode
// RULE9 - Integrator keeps second y unsigned in plus-wide
// RULE10 - Difference select subtracts top from bottom product
// RULE11 - Difference select stage, default bypassed
// RULE12 - Primary result width 1-64, default 37
// RULE13 - Secondary result only in dual independent mode
// RULE14 - One output stage choice for both results
// RULE15 - Sum mode: bottom plus or minus top
// RULE16 - Integrator sign-extends narrow wide addend
// RULE17 - Bypassed stage adds no latency
// RULE18 - Registered stage loads only when enabled
module fpm_top #(
  parameter [2:0] OPERATION_MODE                 = `FPM_MODE_DUAL_IND_MID,
  parameter       FIRST_X_SIGNED                 = 0,
  parameter       FIRST_Y_SIGNED                 = 0,
  parameter       SECOND_X_SIGNED                = 0,
  parameter       SECOND_Y_SIGNED                = 0,
  parameter       THIRD_X_SIGNED                 = 0,
  parameter       THIRD_Y_SIGNED                 = 0,
  parameter       FOURTH_X_SIGNED                = 0,
  parameter       FOURTH_Y_SIGNED                = 0,
  parameter       FIRST_X_WIDTH                  = `FPM_DEF_MID_WIDTH,
  parameter       FIRST_Y_OR_CASCADE_WIDTH       = `FPM_DEF_MID_WIDTH,
  parameter       SECOND_X_WIDTH                 = `FPM_DEF_MID_WIDTH,
  parameter       SECOND_Y_WIDTH                 = `FPM_DEF_MID_WIDTH,
  parameter       THIRD_X_WIDTH                  = `FPM_DEF_SMALL_W,
  parameter       THIRD_Y_WIDTH                  = `FPM_DEF_SMALL_W,
  parameter       FOURTH_X_WIDTH                 = `FPM_DEF_SMALL_W,
  parameter       FOURTH_Y_WIDTH                 = `FPM_DEF_SMALL_W,
  parameter [1:0] FIRST_X_REGISTER_ENABLE_CHOICE = `FPM_REG_CE0,
  parameter [1:0] FIRST_Y_REG_CHOICE             = `FPM_REG_CE0,
  parameter [1:0] SECOND_X_REG_CHOICE            = `FPM_REG_CE0,
  parameter [1:0] SECOND_Y_REG_CHOICE            = `FPM_REG_CE0,
  parameter [1:0] THIRD_X_REG_CHOICE             = `FPM_REG_BYPASS,
  parameter [1:0] THIRD_Y_REG_CHOICE             = `FPM_REG_BYPASS,
  parameter [1:0] FOURTH_X_REG_CHOICE            = `FPM_REG_BYPASS,
  parameter [1:0] FOURTH_Y_REG_CHOICE            = `FPM_REG_BYPASS,
  parameter       ENABLE_DIFF_SELECT             = 0,
  parameter [1:0] DIFF_SELECT_REG_CHOICE         = `FPM_REG_BYPASS,
  parameter       PRIMARY_WIDTH                  = `FPM_DEF_RES_WIDTH,
  parameter       SECONDARY_WIDTH                = `FPM_DEF_RES_WIDTH,
  parameter [1:0] OUTPUT_REG_CHOICE              = `FPM_REG_CE0
) (
  // Clock and reset
  input  wire                        aclk,
  input  wire                        aresetn,
  // Clock enables
  input  wire                        clock_enable_zero,
  input  wire                        clock_enable_one,
  input  wire                        clock_enable_two,
  // Operands
  input  wire [`FPM_PW(FIRST_X_WIDTH)-1:0]  first_mult_x_operand,
  input  wire [`FPM_PW(FIRST_Y_OR_CASCADE_WIDTH)-1:0]
                                     first_mult_y_operand,
  input  wire [`FPM_PW(SECOND_X_WIDTH)-1:0] second_mult_x_operand,
  input  wire [`FPM_PW(SECOND_Y_WIDTH)-1:0] second_mult_y_operand,
  input  wire [`FPM_PW(THIRD_X_WIDTH)-1:0]  third_mult_x_operand,
  input  wire [`FPM_PW(THIRD_Y_WIDTH)-1:0]  third_mult_y_operand,
  input  wire [`FPM_PW(FOURTH_X_WIDTH)-1:0] fourth_mult_x_operand,
  input  wire [`FPM_PW(FOURTH_Y_WIDTH)-1:0] fourth_mult_y_operand,
  input  wire                        diff_select,
  // Results
  output wire [`FPM_PW(PRIMARY_WIDTH)-1:0]   primary_result,
  output wire [`FPM_PW(SECONDARY_WIDTH)-1:0] secondary_result,
  // AXI4-Lite write address and data
  input  wire [`FPM_ADDR_W-1:0]      s_axi_awaddr,
  input  wire                        s_axi_awvalid,
  output wire                        s_axi_awready,
  input  wire [31:0]                 s_axi_wdata,
  input  wire [3:0]                  s_axi_wstrb,
  input  wire                        s_axi_wvalid,
  output wire                        s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0]                  s_axi_bresp,
  output wire                        s_axi_bvalid,
  input  wire                        s_axi_bready,
  // AXI4-Lite read
  input  wire [`FPM_ADDR_W-1:0]      s_axi_araddr,
  input  wire                        s_axi_arvalid,
  output wire                        s_axi_arready,
  output wire [31:0]                 s_axi_rdata,
  output wire [1:0]                  s_axi_rresp,
  output wire                        s_axi_rvalid,
  input  wire                        s_axi_rready
);

  localparam CW   = `FPM_CALC_WIDTH;
  localparam PX1  = `FPM_PW(FIRST_X_WIDTH);
  localparam PY1  = `FPM_PW(FIRST_Y_OR_CASCADE_WIDTH);
  localparam PX2  = `FPM_PW(SECOND_X_WIDTH);
  localparam PY2  = `FPM_PW(SECOND_Y_WIDTH);
  localparam PX3  = `FPM_PW(THIRD_X_WIDTH);
  localparam PY3  = `FPM_PW(THIRD_Y_WIDTH);
  localparam PX4  = `FPM_PW(FOURTH_X_WIDTH);
  localparam PY4  = `FPM_PW(FOURTH_Y_WIDTH);
  localparam PRA  = `FPM_PW(PRIMARY_WIDTH);
  localparam PRB  = `FPM_PW(SECONDARY_WIDTH);
  localparam QUAD = (OPERATION_MODE == `FPM_MODE_QUAD_SMALL_SUM);
  // Modes in which the difference select exists
  localparam MIDM = (OPERATION_MODE == `FPM_MODE_DUAL_IND_MID) ||
                    (OPERATION_MODE == `FPM_MODE_DUAL_MID_SUM) ||
                    (OPERATION_MODE == `FPM_MODE_MID_PLUS_WIDE) ||
                    (OPERATION_MODE == `FPM_MODE_MID_SYSTOLIC);

  // Sign or zero extension of a w-bit operand to the calculation width
  function [63:0] fpm_ext;
    input [63:0] v;
    input integer w;
    input         s;
    integer       i;
    begin
      fpm_ext = 64'h0000_0000_0000_0000;
      for (i = 0; i < 64; i = i + 1) begin
        if (i < w) begin
          fpm_ext[i] = v[i];
        end else if (s && (w > 0)) begin
          fpm_ext[i] = v[w-1];
        end
      end
    end
  endfunction

  // Register address decode, shared by read and write paths
  function fpm_mapped;
    input [`FPM_ADDR_W-1:0] a;
    begin
      fpm_mapped = (a == `FPM_OFS_CTRL) || (a == `FPM_OFS_STATUS) ||
                   (a == `FPM_OFS_RESULT_LO) || (a == `FPM_OFS_RESULT_HI);
    end
  endfunction

  reg        hold_r;
  wire [2:0] en;

  // Software hold freezes every registered stage
  assign en = {clock_enable_two, clock_enable_one, clock_enable_zero} &
              ~{3{hold_r}};

  // Input stages
  wire [PX1-1:0] x1_q;
  wire [PY1-1:0] y1_q;
  wire [PX2-1:0] x2_q;
  wire [PY2-1:0] y2_q;
  wire [PX3-1:0] x3_q;
  wire [PY3-1:0] y3_q;
  wire [PX4-1:0] x4_q;
  wire [PY4-1:0] y4_q;
  wire           sub_q;

  // [RULE7]
  fpm_stage #(.W(PX1), .SEL(FIRST_X_REGISTER_ENABLE_CHOICE)) u_x1 (
    .aclk(aclk), .aresetn(aresetn), .en(en),
    .d(first_mult_x_operand), .q(x1_q));
  fpm_stage #(.W(PY1), .SEL(FIRST_Y_REG_CHOICE)) u_y1 (
    .aclk(aclk), .aresetn(aresetn), .en(en),
    .d(first_mult_y_operand), .q(y1_q));
  fpm_stage #(.W(PX2), .SEL(SECOND_X_REG_CHOICE)) u_x2 (
    .aclk(aclk), .aresetn(aresetn), .en(en),
    .d(second_mult_x_operand), .q(x2_q));
  fpm_stage #(.W(PY2), .SEL(SECOND_Y_REG_CHOICE)) u_y2 (
    .aclk(aclk), .aresetn(aresetn), .en(en),
    .d(second_mult_y_operand), .q(y2_q));
  // [RULE8]
  fpm_stage #(.W(PX3), .SEL(THIRD_X_REG_CHOICE)) u_x3 (
    .aclk(aclk), .aresetn(aresetn), .en(en),
    .d(third_mult_x_operand), .q(x3_q));
  fpm_stage #(.W(PY3), .SEL(THIRD_Y_REG_CHOICE)) u_y3 (
    .aclk(aclk), .aresetn(aresetn), .en(en),
    .d(third_mult_y_operand), .q(y3_q));
  fpm_stage #(.W(PX4), .SEL(FOURTH_X_REG_CHOICE)) u_x4 (
    .aclk(aclk), .aresetn(aresetn), .en(en),
    .d(fourth_mult_x_operand), .q(x4_q));
  fpm_stage #(.W(PY4), .SEL(FOURTH_Y_REG_CHOICE)) u_y4 (
    .aclk(aclk), .aresetn(aresetn), .en(en),
    .d(fourth_mult_y_operand), .q(y4_q));
  // [RULE11]
  fpm_stage #(.W(1), .SEL(DIFF_SELECT_REG_CHOICE)) u_sub (
    .aclk(aclk), .aresetn(aresetn), .en(en),
    .d(diff_select), .q(sub_q));

  // Extended operands; signedness per operand [RULE2]
  wire [CW-1:0] x1 = fpm_ext({{(CW-PX1){1'b0}}, x1_q}, FIRST_X_WIDTH,
                             FIRST_X_SIGNED != 0); // [RULE3]
  wire [CW-1:0] y1 = fpm_ext({{(CW-PY1){1'b0}}, y1_q},
                             FIRST_Y_OR_CASCADE_WIDTH,
                             FIRST_Y_SIGNED != 0); // [RULE4]
  wire [CW-1:0] x2 = fpm_ext({{(CW-PX2){1'b0}}, x2_q}, SECOND_X_WIDTH,
                             SECOND_X_SIGNED != 0); // [RULE5]
  wire [CW-1:0] y2 = fpm_ext({{(CW-PY2){1'b0}}, y2_q}, SECOND_Y_WIDTH,
                             SECOND_Y_SIGNED != 0); // [RULE6]
  wire [CW-1:0] x3 = fpm_ext({{(CW-PX3){1'b0}}, x3_q}, THIRD_X_WIDTH,
                             THIRD_X_SIGNED != 0);
  wire [CW-1:0] y3 = fpm_ext({{(CW-PY3){1'b0}}, y3_q}, THIRD_Y_WIDTH,
                             THIRD_Y_SIGNED != 0);
  wire [CW-1:0] x4 = fpm_ext({{(CW-PX4){1'b0}}, x4_q}, FOURTH_X_WIDTH,
                             FOURTH_X_SIGNED != 0);
  wire [CW-1:0] y4 = fpm_ext({{(CW-PY4){1'b0}}, y4_q}, FOURTH_Y_WIDTH,
                             FOURTH_Y_SIGNED != 0);

  // Low 64 bits of a two's complement product are exact for both formats
  wire [CW-1:0] p_top = x1 * y1;
  wire [CW-1:0] p_bot = x2 * y2;
  wire [CW-1:0] p_c   = QUAD ? x3 * y3 : {CW{1'b0}}; // [RULE8]
  wire [CW-1:0] p_d   = QUAD ? x4 * y4 : {CW{1'b0}};
  // The difference select only acts where it exists [RULE10]
  wire          sub_eff = (ENABLE_DIFF_SELECT != 0) && MIDM && sub_q;

  reg [CW-1:0] res_a;
  reg [CW-1:0] res_b;

  always @* begin
    res_a = {CW{1'b0}};
    res_b = {CW{1'b0}};
    case (OPERATION_MODE) // [RULE1]
      `FPM_MODE_QUAD_SMALL_SUM: begin
        res_a = p_top + p_bot + p_c + p_d;
      end
      `FPM_MODE_DUAL_IND_MID: begin
        res_a = p_top;
        res_b = p_bot; // [RULE13]
      end
      `FPM_MODE_DUAL_MID_SUM, `FPM_MODE_MID_SYSTOLIC: begin
        res_a = sub_eff ? p_bot - p_top : p_bot + p_top; // [RULE15]
      end
      `FPM_MODE_MID_PLUS_WIDE: begin
        // Second x is the wide addend, already extended by the integrator
        res_a = sub_eff ? x2 - p_top : x2 + p_top; // [RULE16] [RULE10]
      end
      `FPM_MODE_SINGLE_WIDE: begin
        res_a = p_top;
      end
      default: begin
        res_a = {CW{1'b0}};
      end
    endcase
  end

  // Output stages share one choice [RULE14]
  wire [PRA-1:0] ra_d = res_a[PRA-1:0]; // [RULE12]
  wire [PRB-1:0] rb_d = (SECONDARY_WIDTH > 0) ? res_b[PRB-1:0]
                                              : {PRB{1'b0}};

  fpm_stage #(.W(PRA), .SEL(OUTPUT_REG_CHOICE)) u_ra (
    .aclk(aclk), .aresetn(aresetn), .en(en),
    .d(ra_d), .q(primary_result));
  fpm_stage #(.W(PRB), .SEL(OUTPUT_REG_CHOICE)) u_rb (
    .aclk(aclk), .aresetn(aresetn), .en(en),
    .d(rb_d), .q(secondary_result));

  // Register bus slave
  reg                   aw_got_r;
  reg [`FPM_ADDR_W-1:0] awaddr_r;
  reg                   w_got_r;
  reg [31:0]            wdata_r;
  reg [3:0]             wstrb_r;
  reg                   bvalid_r;
  reg [1:0]             bresp_r;
  reg                   rvalid_r;
  reg [31:0]            rdata_r;
  reg [1:0]             rresp_r;
  reg [31:0]            rd_nxt;

  wire                   aw_hs = s_axi_awvalid & s_axi_awready;
  wire                   w_hs  = s_axi_wvalid & s_axi_wready;
  wire                   aw_now = aw_got_r | aw_hs;
  wire                   w_now  = w_got_r | w_hs;
  wire                   do_wr  = aw_now & w_now;
  wire [`FPM_ADDR_W-1:0] wa = aw_got_r ? awaddr_r : s_axi_awaddr;
  wire [31:0]            wd = w_got_r ? wdata_r : s_axi_wdata;
  wire [3:0]             ws = w_got_r ? wstrb_r : s_axi_wstrb;
  wire [63:0]            ra_wide = {{(CW-PRA){1'b0}}, primary_result};

  assign s_axi_awready = ~aw_got_r & ~bvalid_r;
  assign s_axi_wready  = ~w_got_r & ~bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      awaddr_r <= {`FPM_ADDR_W{1'b0}};
      w_got_r  <= 1'b0;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r  <= `FPM_RESP_OKAY;
      hold_r   <= `FPM_CTRL_RESET;
    end else if (do_wr) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      bvalid_r <= 1'b1;
      bresp_r  <= fpm_mapped(wa) ? `FPM_RESP_OKAY : `FPM_RESP_SLVERR;
      if ((wa == `FPM_OFS_CTRL) && ws[0]) begin
        hold_r <= wd[`FPM_CTRL_HOLD_BIT];
      end
    end else begin
      if (aw_hs) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always @* begin
    case (s_axi_araddr)
      `FPM_OFS_CTRL:      rd_nxt = {31'h0000_0000, hold_r};
      `FPM_OFS_STATUS:    rd_nxt = {27'h000_0000, sub_eff, hold_r,
                                    OPERATION_MODE};
      `FPM_OFS_RESULT_LO: rd_nxt = ra_wide[31:0];
      `FPM_OFS_RESULT_HI: rd_nxt = ra_wide[63:32];
      default:            rd_nxt = 32'h0000_0000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `FPM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_nxt;
      rresp_r  <= fpm_mapped(s_axi_araddr) ? `FPM_RESP_OKAY
                                           : `FPM_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### pkg/fpm_map.vh
// Constants for the fixed-point multiply block: modes, register choices, map
`ifndef FPM_MAP_VH
`define FPM_MAP_VH

// Operation modes
`define FPM_MODE_QUAD_SMALL_SUM  3'h0
`define FPM_MODE_DUAL_IND_MID    3'h1
`define FPM_MODE_DUAL_MID_SUM    3'h2
`define FPM_MODE_MID_PLUS_WIDE   3'h3
`define FPM_MODE_MID_SYSTOLIC    3'h4
`define FPM_MODE_SINGLE_WIDE     3'h5

// Stage register choices
`define FPM_REG_BYPASS 2'h0
`define FPM_REG_CE0    2'h1
`define FPM_REG_CE1    2'h2
`define FPM_REG_CE2    2'h3

// Default widths
`define FPM_DEF_MID_WIDTH  18
`define FPM_DEF_SMALL_W    0
`define FPM_DEF_RES_WIDTH  37
`define FPM_CALC_WIDTH     64

// Port width for a bus that may be configured to zero bits
`define FPM_PW(w) (((w) > 0) ? (w) : 1)

// Register bus map
`define FPM_ADDR_W        8
`define FPM_OFS_CTRL      8'h00
`define FPM_OFS_STATUS    8'h04
`define FPM_OFS_RESULT_LO 8'h08
`define FPM_OFS_RESULT_HI 8'h0C
`define FPM_CTRL_HOLD_BIT 0
`define FPM_CTRL_RESET    1'h0
`define FPM_RESP_OKAY     2'h0
`define FPM_RESP_SLVERR   2'h2

`endif

// ### logic/fpm_stage.v
// One optional stage register: bypass or capture under a chosen enable
`timescale 1ns/10ps
`default_nettype none
`include "fpm_map.vh"

module fpm_stage #(
  parameter       W   = 1,
  parameter [1:0] SEL = `FPM_REG_BYPASS
) (
  // Clock and reset
  input  wire         aclk,
  input  wire         aresetn,
  // Clock enables, bit 0 is enable zero
  input  wire [2:0]   en,
  // Data
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

  generate
    if (SEL == `FPM_REG_BYPASS) begin : g_bypass
      assign q = d; // [RULE17]
    end else begin : g_reg
      reg  [W-1:0] q_r;
      wire         ce;
      assign ce = en[SEL - 2'h1];
      always @(posedge aclk) begin
        if (!aresetn) begin
          q_r <= {W{1'b0}};
        end else if (ce) begin
          q_r <= d; // [RULE18]
        end
      end
      assign q = q_r;
    end
  endgenerate

endmodule
`default_nettype wire

// ### tb/fpm_top_asserts.sv
// Checker for the fixed-point multiply block in dual sum mode
`timescale 1ns/10ps
`default_nettype none
`include "fpm_map.vh"
module fpm_top_asserts #(
  parameter W_X = 18,
  parameter W_P = 37
) (
  // Clock, reset and enables
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 clock_enable_zero,
  input wire logic                 clock_enable_one,
  // Operands and results
  input wire logic [W_X-1:0]       first_mult_x_operand,
  input wire logic [W_X-1:0]       first_mult_y_operand,
  input wire logic [W_X-1:0]       second_mult_x_operand,
  input wire logic [W_X-1:0]       second_mult_y_operand,
  input wire logic                 diff_select,
  input wire logic [W_P-1:0]       primary_result,
  input wire logic [W_P-1:0]       secondary_result,
  // Register bus
  input wire logic [`FPM_ADDR_W-1:0] s_axi_awaddr,
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic [31:0]          s_axi_wdata,
  input wire logic [3:0]           s_axi_wstrb,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic [1:0]           s_axi_rresp,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready
);
  logic [W_X-1:0] x1_r, y1_r, x2_r, y2_r;
  logic           hold_r;
  logic [63:0]    sum_w, dif_w;
  logic [W_P-1:0] sum_p, dif_p;

  assign sum_w = 64'(x2_r) * 64'(y2_r) + 64'(x1_r) * 64'(y1_r);
  assign dif_w = 64'(x2_r) * 64'(y2_r) - 64'(x1_r) * 64'(y1_r);
  assign sum_p = sum_w[W_P-1:0];
  assign dif_p = dif_w[W_P-1:0];

  // Mirror of the input stage and of the hold bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_r <= 1'b0;
      x1_r   <= '0;
      y1_r   <= '0;
      x2_r   <= '0;
      y2_r   <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
          s_axi_awaddr == `FPM_OFS_CTRL && s_axi_wstrb[0])
        hold_r <= s_axi_wdata[`FPM_CTRL_HOLD_BIT];
      if (clock_enable_zero && !hold_r) begin
        x1_r <= first_mult_x_operand;
        y1_r <= first_mult_y_operand;
        x2_r <= second_mult_x_operand;
        y2_r <= second_mult_y_operand;
      end
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_out_hold;
    (!clock_enable_one || hold_r) |=> $stable(primary_result);
  endproperty
  property p_sum;
    clock_enable_one && !hold_r && !diff_select |=> primary_result == $past(sum_p);
  endproperty
  property p_diff;
    clock_enable_one && !hold_r && diff_select |=> primary_result == $past(dif_p);
  endproperty
  property p_sec_zero;
    secondary_result == '0;
  endproperty
  property p_b_after_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
  endproperty
  property p_b_stands;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  property p_r_after_ar;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  property p_r_stands;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_err_data;
    s_axi_rvalid && s_axi_rresp == `FPM_RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000;
  endproperty

  a_out_hold: assert property (p_out_hold)
    else $error("Result changed while its stage was not enabled");
  a_sum: assert property (p_sum)
    else $error("Result is not the sum of the two products");
  a_diff: assert property (p_diff)
    else $error("Result is not bottom minus top product");
  a_sec_zero: assert property (p_sec_zero)
    else $error("Secondary result driven outside its mode");
  a_b_after_wr: assert property (p_b_after_wr)
    else $error("Write response missing after address and data");
  a_b_stands: assert property (p_b_stands)
    else $error("Write response dropped before it was taken");
  a_r_after_ar: assert property (p_r_after_ar)
    else $error("Read data missing after read address");
  a_r_stands: assert property (p_r_stands)
    else $error("Read data dropped or changed before it was taken");
  a_err_data: assert property (p_err_data)
    else $error("Error read returned nonzero data");

  c_diff: cover property (clock_enable_one && diff_select);
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_err: cover property (s_axi_rvalid && s_axi_rresp == `FPM_RESP_SLVERR);
endmodule
`default_nettype wire

// ### tb/fpm_fabric.sv
// Fabric-side model that drives operand buses and stage enables
`timescale 1ns/10ps
`default_nettype none
module fpm_fabric (
  // Clock
  input  wire logic        aclk,
  // Operands, difference select and enables toward the block
  output var  logic [17:0] x1,
  output var  logic [17:0] y1,
  output var  logic [17:0] x2,
  output var  logic [17:0] y2,
  output var  logic        diff,
  output var  logic [2:0]  ce
);
  initial begin
    x1 = '0;
    y1 = '0;
    x2 = '0;
    y2 = '0;
    diff = 1'b0;
    ce = 3'b000;
  end

  // New values land just after an edge and stand until the next call
  // Second y is always given as an unsigned value
  task automatic put(input logic [17:0] a, b, c, d, input logic s,
                     input logic [2:0] e);
    @(posedge aclk);
    x1 <= a;
    y1 <= b;
    x2 <= c;
    y2 <= d;
    diff <= s;
    ce <= e;
  endtask
endmodule
`default_nettype wire

// ### tb/fpm_top_tb.sv
// Self-checking bench for the fixed-point multiply block in dual sum mode
`timescale 1ns/10ps
`default_nettype none
`include "fpm_map.vh"
module fpm_top_tb;
  logic        aclk, aresetn, diff;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [17:0] x1, y1, x2, y2;
  logic [2:0]  ce;
  logic [36:0] primary_result, secondary_result;
  logic [63:0] last_e;
  int          err_total, checks_done;

  fpm_top #(
    .OPERATION_MODE(`FPM_MODE_DUAL_MID_SUM),
    .ENABLE_DIFF_SELECT(1),
    .OUTPUT_REG_CHOICE(`FPM_REG_CE1)
  ) u_fpm_top (
    .aclk(aclk), .aresetn(aresetn), .clock_enable_zero(ce[0]),
    .clock_enable_one(ce[1]), .clock_enable_two(ce[2]),
    .first_mult_x_operand(x1), .first_mult_y_operand(y1),
    .second_mult_x_operand(x2), .second_mult_y_operand(y2),
    .third_mult_x_operand(1'b0), .third_mult_y_operand(1'b0),
    .fourth_mult_x_operand(1'b0), .fourth_mult_y_operand(1'b0),
    .diff_select(diff), .primary_result(primary_result),
    .secondary_result(secondary_result),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );

  fpm_fabric u_fpm_fabric (
    .aclk(aclk), .x1(x1), .y1(y1), .x2(x2), .y2(y2), .diff(diff), .ce(ce)
  );

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic check(input logic [63:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One register access; each answer is taken at the edge that sees it
  task automatic axi(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bready <= 1'b0;
        check(s_axi_bresp, er, "write response");
        done = 1'b1;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rready <= 1'b0;
        check(s_axi_rresp, er, "read response");
        check(s_axi_rdata, d, "read data");
        done = 1'b1;
      end
    end
  endtask

  // Operands in, two enabled edges, then the result is compared
  task automatic op(input logic [17:0] a, b, c, d, input logic s);
    last_e = {46'h0, c} * {46'h0, d};
    if (s) last_e = last_e - {46'h0, a} * {46'h0, b};
    else last_e = last_e + {46'h0, a} * {46'h0, b};
    u_fpm_fabric.put(a, b, c, d, s, 3'b011);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    check(primary_result, last_e[36:0], "result");
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    print_verdict();
  end

  initial begin
    err_total = 0;
    checks_done = 0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    settle(1);
    check(secondary_result, 0, "secondary");
    axi(0, `FPM_OFS_STATUS, 32'h0000_0002, `FPM_RESP_OKAY);
    op(18'h0_0003, 18'h0_0005, 18'h0_0007, 18'h0_0002, 1'b0);
    op(18'h3_FFFF, 18'h3_FFFF, 18'h3_FFFF, 18'h3_FFFF, 1'b0);
    op(18'h0_0003, 18'h0_0005, 18'h0_0007, 18'h0_0002, 1'b1);
    op(18'h3_FFFF, 18'h3_FFFF, 18'h0_0000, 18'h1_2345, 1'b1);
    op(18'h1_2345, 18'h2_0001, 18'h3_0000, 18'h3_FFFF, 1'b1);
    $display("test sum and difference done");
    axi(0, `FPM_OFS_STATUS, 32'h0000_0012, `FPM_RESP_OKAY);
    axi(0, `FPM_OFS_RESULT_LO, last_e[31:0], `FPM_RESP_OKAY);
    axi(0, `FPM_OFS_RESULT_HI, {27'h0, last_e[36:32]}, `FPM_RESP_OKAY);
    axi(1, `FPM_OFS_RESULT_LO, 32'h1234_5678, `FPM_RESP_OKAY);
    axi(0, `FPM_OFS_RESULT_LO, last_e[31:0], `FPM_RESP_OKAY);
    axi(0, 8'h10, 32'h0000_0000, `FPM_RESP_SLVERR);
    axi(1, 8'h10, 32'hFFFF_FFFF, `FPM_RESP_SLVERR);
    $display("test register bus done");
    u_fpm_fabric.put(18'h0_0010, 18'h0_0010, 18'h0_0001, 18'h0_0001, 1'b0, 3'b001);
    settle(3);
    check(primary_result, last_e[36:0], "held output");
    u_fpm_fabric.put(18'h0_0020, 18'h0_0020, 18'h0_0000, 18'h0_0000, 1'b0, 3'b010);
    settle(1);
    check(primary_result, 37'h0_0000_0101, "input stage held");
    u_fpm_fabric.put(18'h0_0004, 18'h0_0004, 18'h0_0004, 18'h0_0004, 1'b0, 3'b100);
    settle(3);
    check(primary_result, 37'h0_0000_0101, "other enable");
    $display("test stage enables done");
    axi(1, `FPM_OFS_CTRL, 32'h0000_0001, `FPM_RESP_OKAY);
    axi(0, `FPM_OFS_STATUS, 32'h0000_000A, `FPM_RESP_OKAY);
    u_fpm_fabric.put(18'h0_0005, 18'h0_0005, 18'h0_0005, 18'h0_0005, 1'b0, 3'b011);
    settle(3);
    check(primary_result, 37'h0_0000_0101, "hold");
    axi(1, `FPM_OFS_CTRL, 32'h0000_0000, `FPM_RESP_OKAY);
    op(18'h0_0005, 18'h0_0005, 18'h0_0005, 18'h0_0005, 1'b0);
    $display("test hold done");
    print_verdict();
  end
endmodule

bind fpm_top fpm_top_asserts #(.W_X(FIRST_X_WIDTH), .W_P(PRIMARY_WIDTH))
  u_fpm_top_asserts (.*);
`default_nettype wire
